// ==== rtl/srm_pkg.sv ====
// Shared constants and carrier types of the status reporting model
package srm_pkg;
  localparam int SRM_W = 16;
  localparam int SRM_MSB = 15;
  localparam int SRM_HW_W = 15;
  localparam int SRM_NREG = 3;
  localparam logic [15:0] SRM_DATA_MASK = 16'h7fff;
  localparam logic [15:0] SRM_PTR_RST = 16'h7fff;
  localparam logic [15:0] SRM_NTR_RST = 16'h0000;
  localparam logic [15:0] SRM_ENA_RST = 16'h0000;
  localparam int SRM_OPER_CAL_BIT = 0;
  localparam int SRM_STB_W = 8;
  localparam logic [7:0] SRM_SRE_RST = 8'h00;
  localparam int SRM_STB_ERRQ = 2;
  localparam int SRM_STB_QUES = 3;
  localparam int SRM_STB_MAV = 4;
  localparam int SRM_STB_ESB = 5;
  localparam int SRM_STB_RQS = 6;
  localparam int SRM_STB_OPER = 7;
  localparam logic [1:0] SRM_SEL_OPER = 2'h0;
  localparam logic [1:0] SRM_SEL_QUES = 2'h1;
  localparam logic [1:0] SRM_SEL_ESR = 2'h2;
  localparam logic [1:0] SRM_SEL_STB = 2'h3;
  localparam logic [2:0] SRM_PART_COND = 3'h0;
  localparam logic [2:0] SRM_PART_PTR = 3'h1;
  localparam logic [2:0] SRM_PART_NTR = 3'h2;
  localparam logic [2:0] SRM_PART_EVT = 3'h3;
  localparam logic [2:0] SRM_PART_ENA = 3'h4;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] sel;
    logic [2:0] part;
    logic [15:0] wdata;
  } srm_req_type;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } srm_rsp_type;
  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] evt;
    logic [15:0] ena;
  } srm_parts_type;
endpackage

// ==== rtl/srm_status_reg.sv ====
// One five-part status register with edge filters and summary
`timescale 1ns/1ps
`default_nettype none
module srm_status_reg
  import srm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] cond_in,
  input wire logic wr_ptr,
  input wire logic wr_ntr,
  input wire logic wr_ena,
  input wire logic [15:0] wdata,
  input wire logic evt_clr,
  output var srm_parts_type parts,
  output logic summary
);
  logic [15:0] cond_reg, cond_next, ptr_reg, ptr_next, ntr_reg, ntr_next;
  logic [15:0] evt_reg, evt_next, ena_reg, ena_next;
  logic sum_reg, sum_next;
  logic [15:0] cond_m, rise_hit, fall_hit, hit_any;

  assign cond_m = cond_in & SRM_DATA_MASK;
  assign rise_hit = cond_m & ~cond_reg & ptr_reg;
  assign fall_hit = ~cond_m & cond_reg & ntr_reg;
  assign hit_any = rise_hit | fall_hit;

  always_comb
  begin
    cond_next = cond_m;
    ptr_next = wr_ptr ? (wdata & SRM_DATA_MASK) : ptr_reg;
    ntr_next = wr_ntr ? (wdata & SRM_DATA_MASK) : ntr_reg;
    ena_next = wr_ena ? (wdata & SRM_DATA_MASK) : ena_reg;
    // Set wins over the clearing read
    evt_next = (evt_clr ? 16'h0000 : evt_reg) | hit_any;
    sum_next = |(evt_next & ena_next);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cond_reg <= 16'h0000;
      ptr_reg <= SRM_PTR_RST;
      ntr_reg <= SRM_NTR_RST;
      evt_reg <= 16'h0000;
      ena_reg <= SRM_ENA_RST;
      sum_reg <= 1'b0;
    end
    else
    begin
      cond_reg <= cond_next;
      ptr_reg <= ptr_next;
      ntr_reg <= ntr_next;
      evt_reg <= evt_next;
      ena_reg <= ena_next;
      sum_reg <= sum_next;
    end
  end

  assign parts = '{cond: cond_reg, ptr: ptr_reg, ntr: ntr_reg, evt: evt_reg, ena: ena_reg};
  assign summary = sum_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_msb_zero;
    !(cond_reg[SRM_MSB] | ptr_reg[SRM_MSB] | ntr_reg[SRM_MSB] | evt_reg[SRM_MSB]
      | ena_reg[SRM_MSB]);
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("msb of a part set");
  property p_rise_sets;
    (rise_hit != 16'h0000) |=> ((evt_reg & $past(rise_hit)) == $past(rise_hit));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise not latched");
  property p_fall_sets;
    (fall_hit != 16'h0000) |=> ((evt_reg & $past(fall_hit)) == $past(fall_hit));
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall not latched");
  property p_no_spurious;
    1 |=> ((evt_reg & ~$past(evt_reg) & ~$past(hit_any)) == 16'h0000);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("unfiltered event");
  property p_read_clears;
    evt_clr |=> (evt_reg == $past(hit_any));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read clear wrong");
  property p_cond_follows;
    1 |=> (cond_reg == $past(cond_m));
  endproperty
  a_cond_follows: assert property (p_cond_follows) else $error("cond stale");
  property p_summary;
    summary == |(evt_reg & ena_reg);
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");
  c_clear_and_set: cover property (evt_clr && (hit_any != 16'h0000));
endmodule
`default_nettype wire

// ==== rtl/srm_srq_gen.sv ====
// Status byte, request mask and service request edge
`timescale 1ns/1ps
`default_nettype none
module srm_srq_gen
  import srm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] stb_in,
  input wire logic sre_wr,
  input wire logic [7:0] wdata,
  output logic [7:0] stb,
  output logic [7:0] sre,
  output logic srq
);
  localparam logic [7:0] RQS_MASK = 8'h01 << SRM_STB_RQS;
  logic [7:0] stb_reg, stb_next, sre_reg, sre_next, stb_m, rise_en;
  logic srq_reg, srq_next;

  assign stb_m = stb_in & ~RQS_MASK;
  assign rise_en = stb_m & ~stb_reg & sre_reg;

  always_comb
  begin
    sre_next = sre_wr ? (wdata & ~RQS_MASK) : sre_reg;
    stb_next = stb_m;
    stb_next[SRM_STB_RQS] = |(stb_m & sre_reg);
    srq_next = |rise_en;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stb_reg <= 8'h00;
      sre_reg <= SRM_SRE_RST;
      srq_reg <= 1'b0;
    end
    else
    begin
      stb_reg <= stb_next;
      sre_reg <= sre_next;
      srq_reg <= srq_next;
    end
  end

  assign stb = stb_reg;
  assign sre = sre_reg;
  assign srq = srq_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_srq_on_rise;
    (rise_en != 8'h00) |=> srq;
  endproperty
  a_srq_on_rise: assert property (p_srq_on_rise) else $error("missed request");
  property p_srq_only_rise;
    (rise_en == 8'h00) |=> !srq;
  endproperty
  a_srq_only_rise: assert property (p_srq_only_rise) else $error("bogus request");
  property p_sre6_zero;
    sre_wr |=> !sre[SRM_STB_RQS];
  endproperty
  a_sre6_zero: assert property (p_sre6_zero) else $error("mask bit 6 kept");
  property p_mav;
    1 |=> (stb[SRM_STB_MAV] == $past(stb_in[SRM_STB_MAV]));
  endproperty
  a_mav: assert property (p_mav) else $error("message bit wrong");
  c_srq: cover property (srq);
endmodule
`default_nettype wire

// ==== rtl/srm_top.sv ====
// Status reporting model: three status registers, status byte, host port
`timescale 1ns/1ps
`default_nettype none
module srm_top
  import srm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [14:0] oper_pin,
  input wire logic [14:0] ques_pin,
  input wire logic [14:0] esr_pin,
  input wire logic err_queue_nonempty,
  input wire logic out_buf_nonempty,
  input var srm_req_type host_req,
  output var srm_rsp_type host_rsp,
  output logic srq,
  output logic [7:0] status_byte
);
  localparam int SYNC_W = 3 * SRM_HW_W;

  // Pins are asynchronous to clk_sys
  logic [SYNC_W-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [15:0] cond_vec [SRM_NREG];
  srm_parts_type parts_vec [SRM_NREG];
  logic [SRM_NREG-1:0] sum_vec;
  logic [SRM_NREG-1:0] wr_ptr, wr_ntr, wr_ena, evt_clr;
  logic [7:0] stb_in, stb, sre;
  logic sre_wr;
  srm_rsp_type rsp_reg, rsp_next;
  logic [15:0] rd_mux;
  logic [15:0] wdata_m;
  logic [15:0] oper_cond;
  logic rqs_src;

  always_comb
  begin
    sync1_next = {esr_pin, ques_pin, oper_pin};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Operation pin 0 is the calibration status
  assign cond_vec[SRM_SEL_OPER] = {1'b0, sync2_reg[SRM_HW_W-1:0]};
  assign cond_vec[SRM_SEL_QUES] = {1'b0, sync2_reg[2*SRM_HW_W-1:SRM_HW_W]};
  assign cond_vec[SRM_SEL_ESR] = {1'b0, sync2_reg[3*SRM_HW_W-1:2*SRM_HW_W]};

  genvar gi;
  generate
    for (gi = 0; gi < SRM_NREG; gi++)
    begin : g_reg
      // Condition part has no write strobe at all
      assign wr_ptr[gi] = host_req.wr && (host_req.sel == 2'(gi))
        && (host_req.part == SRM_PART_PTR);
      assign wr_ntr[gi] = host_req.wr && (host_req.sel == 2'(gi))
        && (host_req.part == SRM_PART_NTR);
      assign wr_ena[gi] = host_req.wr && (host_req.sel == 2'(gi))
        && (host_req.part == SRM_PART_ENA);
      assign evt_clr[gi] = host_req.rd && (host_req.sel == 2'(gi))
        && (host_req.part == SRM_PART_EVT);
      srm_status_reg u_reg (
        .clk_sys(clk_sys),
        .rst(rst),
        .cond_in(cond_vec[gi]),
        .wr_ptr(wr_ptr[gi]),
        .wr_ntr(wr_ntr[gi]),
        .wr_ena(wr_ena[gi]),
        .wdata(host_req.wdata),
        .evt_clr(evt_clr[gi]),
        .parts(parts_vec[gi]),
        .summary(sum_vec[gi])
      );
    end
  endgenerate

  // Summaries climb into the status byte
  always_comb
  begin
    stb_in = 8'h00;
    stb_in[SRM_STB_ERRQ] = err_queue_nonempty;
    stb_in[SRM_STB_QUES] = sum_vec[SRM_SEL_QUES];
    stb_in[SRM_STB_MAV] = out_buf_nonempty;
    stb_in[SRM_STB_ESB] = sum_vec[SRM_SEL_ESR];
    stb_in[SRM_STB_OPER] = sum_vec[SRM_SEL_OPER];
  end

  assign sre_wr = host_req.wr && (host_req.sel == SRM_SEL_STB)
    && (host_req.part == SRM_PART_ENA);

  srm_srq_gen u_srq (
    .clk_sys(clk_sys),
    .rst(rst),
    .stb_in(stb_in),
    .sre_wr(sre_wr),
    .wdata(host_req.wdata[7:0]),
    .stb(stb),
    .sre(sre),
    .srq(srq)
  );

  // Read multiplexer; event reads see the value before the clear
  always_comb
  begin
    rd_mux = 16'h0000;
    if (host_req.sel == SRM_SEL_STB)
    begin
      case (host_req.part)
        SRM_PART_COND: rd_mux = {8'h00, stb};
        SRM_PART_ENA: rd_mux = {8'h00, sre};
        default: rd_mux = 16'h0000;
      endcase
    end
    else
    begin
      case (host_req.part)
        SRM_PART_COND: rd_mux = parts_vec[host_req.sel].cond;
        SRM_PART_PTR: rd_mux = parts_vec[host_req.sel].ptr;
        SRM_PART_NTR: rd_mux = parts_vec[host_req.sel].ntr;
        SRM_PART_EVT: rd_mux = parts_vec[host_req.sel].evt;
        SRM_PART_ENA: rd_mux = parts_vec[host_req.sel].ena;
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  always_comb
  begin
    rsp_next.valid = host_req.rd;
    rsp_next.data = host_req.rd ? (rd_mux & SRM_DATA_MASK) : rsp_reg.data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rsp_reg <= '0;
    end
    else
    begin
      rsp_reg <= rsp_next;
    end
  end

  assign host_rsp = rsp_reg;
  assign status_byte = stb;

  // Helpers watched only by the checks below
  assign wdata_m = host_req.wdata & SRM_DATA_MASK;
  assign oper_cond = parts_vec[SRM_SEL_OPER].cond;
  assign rqs_src = |(stb_in & sre);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_rd_answer;
    host_req.rd |=> host_rsp.valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_stray_valid;
    !host_req.rd |=> !host_rsp.valid;
  endproperty
  a_no_stray_valid: assert property (p_no_stray_valid) else $error("stray answer");
  property p_rsp_msb;
    host_rsp.valid |-> !host_rsp.data[SRM_MSB];
  endproperty
  a_rsp_msb: assert property (p_rsp_msb) else $error("answer msb set");
  property p_ptr_readback;
    (host_req.wr && host_req.sel == SRM_SEL_OPER && host_req.part == SRM_PART_PTR)
      |=> (parts_vec[SRM_SEL_OPER].ptr == $past(wdata_m));
  endproperty
  a_ptr_readback: assert property (p_ptr_readback) else $error("filter write lost");
  property p_ena_readback;
    (host_req.wr && host_req.sel == SRM_SEL_QUES && host_req.part == SRM_PART_ENA)
      |=> (parts_vec[SRM_SEL_QUES].ena == $past(wdata_m));
  endproperty
  a_ena_readback: assert property (p_ena_readback) else $error("enable write lost");
  property p_cond_read;
    (host_req.rd && host_req.sel == SRM_SEL_OPER && host_req.part == SRM_PART_COND)
      |=> (host_rsp.data == $past(oper_cond));
  endproperty
  a_cond_read: assert property (p_cond_read) else $error("condition read wrong");
  property p_cal_bit;
    1 |=> ##1 (oper_cond[SRM_OPER_CAL_BIT] == $past(sync2_reg[SRM_OPER_CAL_BIT]));
  endproperty
  a_cal_bit: assert property (p_cal_bit) else $error("calibration bit lost");
  property p_oper_summary;
    1 |=> (stb[SRM_STB_OPER] == $past(sum_vec[SRM_SEL_OPER]));
  endproperty
  a_oper_summary: assert property (p_oper_summary) else $error("summary not passed");
  property p_ques_summary;
    1 |=> (stb[SRM_STB_QUES] == $past(sum_vec[SRM_SEL_QUES]));
  endproperty
  a_ques_summary: assert property (p_ques_summary) else $error("ques summary lost");
  property p_esr_summary;
    1 |=> (stb[SRM_STB_ESB] == $past(sum_vec[SRM_SEL_ESR]));
  endproperty
  a_esr_summary: assert property (p_esr_summary) else $error("esr summary lost");
  property p_errq;
    1 |=> (status_byte[SRM_STB_ERRQ] == $past(err_queue_nonempty));
  endproperty
  a_errq: assert property (p_errq) else $error("error queue bit wrong");
  property p_stb_unused;
    (status_byte[SRM_STB_ERRQ-1:0] == '0);
  endproperty
  a_stb_unused: assert property (p_stb_unused) else $error("unused status bit set");

  // Master summary uses the mask as it stood one cycle earlier
  property p_rqs_bit;
    1 |=> (status_byte[SRM_STB_RQS] == $past(rqs_src));
  endproperty
  a_rqs_bit: assert property (p_rqs_bit) else $error("master summary wrong");
  property p_sre_write;
    sre_wr |=> (sre[SRM_STB_OPER] == $past(host_req.wdata[SRM_STB_OPER]))
      && (sre[SRM_STB_MAV] == $past(host_req.wdata[SRM_STB_MAV]));
  endproperty
  a_sre_write: assert property (p_sre_write) else $error("mask write lost");

  // Host port side effects; a read must never disturb settings
  property p_ntr_readback;
    (host_req.wr && host_req.sel == SRM_SEL_ESR && host_req.part == SRM_PART_NTR)
      |=> (parts_vec[SRM_SEL_ESR].ntr == $past(wdata_m));
  endproperty
  a_ntr_readback: assert property (p_ntr_readback) else $error("fall filter lost");
  property p_ptr_isolated;
    (host_req.wr && host_req.sel == SRM_SEL_OPER && host_req.part == SRM_PART_PTR)
      |=> $stable(parts_vec[SRM_SEL_QUES].ptr);
  endproperty
  a_ptr_isolated: assert property (p_ptr_isolated) else $error("write leaked");
  property p_read_no_side;
    (host_req.rd && !host_req.wr && host_req.sel == SRM_SEL_OPER)
      |=> $stable(parts_vec[SRM_SEL_OPER].ptr) && $stable(parts_vec[SRM_SEL_OPER].ntr)
        && $stable(parts_vec[SRM_SEL_OPER].ena);
  endproperty
  a_read_no_side: assert property (p_read_no_side) else $error("read changed a part");
  property p_cond_wr_ignored;
    (host_req.wr && host_req.sel == SRM_SEL_QUES && host_req.part == SRM_PART_COND)
      |=> $stable(parts_vec[SRM_SEL_QUES].ptr) && $stable(parts_vec[SRM_SEL_QUES].ntr)
        && $stable(parts_vec[SRM_SEL_QUES].ena);
  endproperty
  a_cond_wr_ignored: assert property (p_cond_wr_ignored) else $error("cond write acted");
  property p_evt_read_answer;
    (host_req.rd && host_req.sel == SRM_SEL_OPER && host_req.part == SRM_PART_EVT)
      |=> (host_rsp.data == $past(parts_vec[SRM_SEL_OPER].evt));
  endproperty
  a_evt_read_answer: assert property (p_evt_read_answer) else $error("event answer wrong");
  property p_unmapped_read;
    (host_req.rd && host_req.part > SRM_PART_ENA) |=> (host_rsp.data == 16'h0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read data");
  property p_stb_read;
    (host_req.rd && host_req.sel == SRM_SEL_STB && host_req.part == SRM_PART_COND)
      |=> (host_rsp.data == {8'h00, $past(stb)});
  endproperty
  a_stb_read: assert property (p_stb_read) else $error("status byte read wrong");
  property p_sre_read;
    (host_req.rd && host_req.sel == SRM_SEL_STB && host_req.part == SRM_PART_ENA)
      |=> (host_rsp.data == {8'h00, $past(sre)});
  endproperty
  a_sre_read: assert property (p_sre_read) else $error("mask read wrong");

  // Answer data must survive until the next read
  property p_data_hold;
    !host_req.rd |=> $stable(host_rsp.data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("answer data moved");
  c_sre_write: cover property (sre_wr);
  c_evt_read: cover property (host_req.rd && host_req.part == SRM_PART_EVT
    && rd_mux != 16'h0000);
  c_ptr_write: cover property (host_req.wr && host_req.part == SRM_PART_PTR);
endmodule
`default_nettype wire

// ==== verification/srm_host_model.sv ====
// Remote host model issuing status queries over the register port
`timescale 1ns/1ps
`default_nettype none
module srm_host_model
  import srm_pkg::*;
(
  input wire logic clk_sys,
  output var srm_req_type host_req,
  input wire srm_rsp_type host_rsp
);
  initial host_req = '0;

  task automatic wr_part(input logic [1:0] sel, input logic [2:0] part, input logic [15:0] data);
    @(posedge clk_sys);
    host_req <= '{rd: 1'b0, wr: 1'b1, sel: sel, part: part, wdata: data};
    @(posedge clk_sys);
    host_req.wr <= 1'b0;
    // Released data lines do not keep the last value
    host_req.wdata <= ~data;
  endtask

  // Status queried over the remote link; answer taken one edge after the strobe
  task automatic rd_part(input logic [1:0] sel, input logic [2:0] part, output logic [15:0] data);
    @(posedge clk_sys);
    host_req <= '{rd: 1'b1, wr: 1'b0, sel: sel, part: part, wdata: 16'h5a5a};
    @(posedge clk_sys);
    host_req.rd <= 1'b0;
    #1;
    if (host_rsp.valid === 1'b1)
      data = host_rsp.data;
    else
      data = 16'hbad0;
  endtask
endmodule
`default_nettype wire

// ==== verification/srm_top_bench.sv ====
// Self-checking bench of the status reporting model
`timescale 1ns/1ps
`default_nettype none
module srm_top_bench
  import srm_pkg::*;
;
  logic clk_sys;
  logic rst;
  logic [14:0] oper_pin;
  logic [14:0] ques_pin;
  logic [14:0] esr_pin;
  logic err_queue_nonempty;
  logic out_buf_nonempty;
  srm_req_type host_req;
  srm_rsp_type host_rsp;
  logic srq;
  logic [7:0] status_byte;
  logic [15:0] rd_val;
  logic [7:0] stb_bit [3] = '{8'h80, 8'h08, 8'h20};
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int srq_cnt = 0;
  int n0;

  srm_top dut_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .oper_pin(oper_pin),
    .ques_pin(ques_pin),
    .esr_pin(esr_pin),
    .err_queue_nonempty(err_queue_nonempty),
    .out_buf_nonempty(out_buf_nonempty),
    .host_req(host_req),
    .host_rsp(host_rsp),
    .srq(srq),
    .status_byte(status_byte)
  );

  srm_host_model host_u (
    .clk_sys(clk_sys),
    .host_req(host_req),
    .host_rsp(host_rsp)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (srq === 1'b1)
      srq_cnt <= srq_cnt + 1;
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input int s, input logic [2:0] part, input logic [15:0] exp);
    host_u.rd_part(2'(s), part, rd_val);
    chk(rd_val, exp);
  endtask

  task automatic wr(input int s, input logic [2:0] part, input logic [15:0] data);
    host_u.wr_part(2'(s), part, data);
  endtask

  // Drives one register's pins, others idle; waits past sync and chain delay
  task automatic set_pin(input int s, input logic [14:0] v);
    @(posedge clk_sys);
    oper_pin <= (s == 0) ? v : 15'h0000;
    ques_pin <= (s == 1) ? v : 15'h0000;
    esr_pin <= (s == 2) ? v : 15'h0000;
    repeat (8) @(posedge clk_sys);
  endtask

  initial
  begin
    rst = 1'b1;
    oper_pin = 15'h0000;
    ques_pin = 15'h0000;
    esr_pin = 15'h0000;
    err_queue_nonempty = 1'b0;
    out_buf_nonempty = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      rd_chk(s, SRM_PART_COND, 16'h0000);
      rd_chk(s, SRM_PART_PTR, SRM_PTR_RST);
      rd_chk(s, SRM_PART_NTR, SRM_NTR_RST);
      rd_chk(s, SRM_PART_EVT, 16'h0000);
      rd_chk(s, SRM_PART_ENA, SRM_ENA_RST);
    end
    $display("test reset values done");
    for (int s = 0; s < 3; s++)
    begin
      wr(s, SRM_PART_PTR, 16'hffff);
      rd_chk(s, SRM_PART_PTR, 16'h7fff);
      rd_chk(s, SRM_PART_PTR, 16'h7fff);
      wr(s, SRM_PART_NTR, 16'h8001);
      rd_chk(s, SRM_PART_NTR, 16'h0001);
      wr(s, SRM_PART_ENA, 16'h8000);
      rd_chk(s, SRM_PART_ENA, 16'h0000);
      wr(s, SRM_PART_ENA, 16'h0000);
      wr(s, SRM_PART_COND, 16'hffff);
      rd_chk(s, SRM_PART_COND, 16'h0000);
      wr(s, SRM_PART_EVT, 16'hffff);
      rd_chk(s, SRM_PART_EVT, 16'h0000);
      rd_chk(s, 3'h7, 16'h0000);
    end
    $display("test part access done");
    for (int s = 0; s < 3; s++)
    begin
      set_pin(s, 15'h0003);
      rd_chk(s, SRM_PART_COND, 16'h0003);
      rd_chk(s, SRM_PART_COND, 16'h0003);
      rd_chk(s, SRM_PART_EVT, 16'h0003);
      rd_chk(s, SRM_PART_EVT, 16'h0000);
      set_pin(s, 15'h0000);
      rd_chk(s, SRM_PART_EVT, 16'h0001);
      wr(s, SRM_PART_PTR, 16'h0002);
      set_pin(s, 15'h0003);
      rd_chk(s, SRM_PART_EVT, 16'h0002);
      wr(s, SRM_PART_PTR, SRM_PTR_RST);
      wr(s, SRM_PART_NTR, 16'h0000);
      set_pin(s, 15'h0000);
      rd_chk(s, SRM_PART_EVT, 16'h0000);
    end
    $display("test edge filters done");
    wr(3, SRM_PART_ENA, 16'hffff);
    rd_chk(3, SRM_PART_ENA, 16'h00bf);
    for (int s = 0; s < 3; s++)
    begin
      wr(s, SRM_PART_ENA, 16'h0001);
      n0 = srq_cnt;
      set_pin(s, 15'h0001);
      rd_chk(s, SRM_PART_COND, 16'h0001);
      chk({8'h00, status_byte}, {8'h00, stb_bit[s] | 8'h40});
      chk(16'(srq_cnt - n0), 16'h0001);
      rd_chk(s, SRM_PART_EVT, 16'h0001);
      repeat (4) @(posedge clk_sys);
      chk({8'h00, status_byte}, 16'h0000);
      set_pin(s, 15'h0000);
      wr(s, SRM_PART_ENA, 16'h0000);
    end
    $display("test summary chain done");
    // Rise lands on the very edge that takes the clearing read
    @(posedge clk_sys);
    oper_pin <= 15'h0004;
    @(posedge clk_sys);
    rd_chk(0, SRM_PART_EVT, 16'h0000);
    rd_chk(0, SRM_PART_EVT, 16'h0004);
    $display("test read race done");
    n0 = srq_cnt;
    @(posedge clk_sys);
    out_buf_nonempty <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({8'h00, status_byte}, 16'h0050);
    err_queue_nonempty <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({8'h00, status_byte}, 16'h0054);
    chk(16'(srq_cnt - n0), 16'h0002);
    rd_chk(3, SRM_PART_COND, 16'h0054);
    $display("test status byte done");
    final_report();
  end
endmodule
`default_nettype wire
